// *** dv/hjd_jack_model.sv ***
// Headset jack model that drives the raw sense lines with contact chatter.
`timescale 1ns/1ps
`default_nettype none
module hjd_jack_model #(
	parameter BOUNCE = 6
) (
	input wire clk,
	input wire logic [4:0] jack_state,
	output logic plug_raw,
	output logic mic_raw,
	output logic left_raw,
	output logic right_raw,
	output logic hook_raw
);
	logic [4:0] last_reg = 5'h00; // Settled contact state.
	logic [4:0] chg_reg = 5'h00; // Contacts that are still moving.
	logic [4:0] line_reg = 5'h00; // Levels on the sense lines.
	int bounce_cnt = 0;
	// Moving contacts toggle every cycle for a while, so a filter that does not
	// restart on a differing sample shows up as an early report.
	always @(posedge clk) begin
		if (jack_state != last_reg) begin
			chg_reg <= jack_state ^ last_reg;
			last_reg <= jack_state;
			bounce_cnt <= BOUNCE;
		end else if (bounce_cnt != 0) begin
			bounce_cnt <= bounce_cnt - 1;
		end
		line_reg <= last_reg ^ (chg_reg & {5{bounce_cnt[0]}});
	end
	assign {plug_raw, mic_raw, left_raw, right_raw, hook_raw} = line_reg;
endmodule
`default_nettype wire

// *** dv/hjd_plug_sense_properties.sv ***
// Port-level properties of the plug sense block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "hjd_consts.vh"
module hjd_plug_sense_properties #(
	parameter ADDR_W = 8
) (
	input wire clk,
	input wire rst_n,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready
);
	// Register index of the read in flight, so read data can be tied to its source.
	reg [5:0] ridx_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ridx_reg <= 6'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ridx_reg <= s_axi_araddr[7:2];
		end
	end
	// A status read is the only place the plug fields are visible.
	wire rd_stat = s_axi_rvalid && ridx_reg == `HJD_IDX_STATUS;
	wire mapped = ridx_reg inside {`HJD_IDX_CTRL, `HJD_IDX_DEB_CFG, `HJD_IDX_STATUS,
		`HJD_IDX_IRQ_STAT, `HJD_IDX_IRQ_MASK};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	chk_stat_reserved: assert property (
		rd_stat |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[7:6] != 2'h2)
		else $error("status reserved bits or code wrong");
	chk_cfg_bit7: assert property (
		s_axi_rvalid && ridx_reg == `HJD_IDX_DEB_CFG |-> !s_axi_rdata[7])
		else $error("debounce config bit 7 not zero");
	chk_layout_unplug: assert property (
		rd_stat && s_axi_rdata[7:6] == `HJD_KIND_NONE |-> s_axi_rdata[5:4] == `HJD_LAYOUT_NONE)
		else $error("layout reported without plug");
	chk_unmapped_err: assert property (
		s_axi_rvalid && !mapped |-> s_axi_rresp == `HJD_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after take");
	chk_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped before rready");
	chk_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
endmodule
bind hjd_plug_sense_top hjd_plug_sense_properties #(.ADDR_W(ADDR_W)) u_props (.clk(clk),
	.rst_n(rst_n), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench: debounce timing table, then reset, reserved and enable tests.
`timescale 1ns/1ps
`default_nettype none
`include "hjd_consts.vh"
module testbench;
	// One row: control, config, jack state, what to watch, expected value, delay window.
	typedef struct {
		logic [7:0] ctrl;
		logic [7:0] cfg;
		logic [4:0] jack;
		bit on_irq;
		logic [7:0] exp;
		int lo;
		int hi;
	} hjd_row_t;
	localparam int TICK = 10; // Cycles per millisecond, shortened for simulation.
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [4:0] jack = 5'h00;
	wire awready, wready, bvalid, arready, rvalid, irq, p_raw, m_raw, l_raw, r_raw, h_raw;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int i;
	logic [31:0] d;
	logic [1:0] resp;
	hjd_row_t rows [0:20];
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	hjd_jack_model u_jack (.clk(clk), .jack_state(jack), .plug_raw(p_raw), .mic_raw(m_raw),
		.left_raw(l_raw), .right_raw(r_raw), .hook_raw(h_raw));
	hjd_plug_sense_top #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.plug_sense_raw(p_raw), .hp_left_sense_raw(l_raw), .hp_right_sense_raw(r_raw),
		.mic_sense_raw(m_raw), .hook_sense_raw(h_raw), .irq(irq));
	// Prints the counts and the verdict, then stops the run.
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// A wait that ran out counts as a mismatch and ends the run.
	task hang(input string name);
		n_fail++;
		$display("[ERR] %s expected answer seen timeout", name);
		end_sim();
	endtask
	// Handshakes are judged at the falling edge, where the registered readies are settled.
	// A late call raises bready only after bvalid is seen, so the slave must hold its answer.
	task wr(input logic [5:0] idx, input logic [7:0] v, input bit late = 1'b0);
		int n;
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !late;
		for (n = 0; n < 40; n++) begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh && bready) begin
				bready <= 1'b0;
				break;
			end
			if (bh)
				bready <= 1'b1;
		end
		if (n == 40)
			hang("bvalid");
	endtask
	task rd(input logic [5:0] idx, input bit late = 1'b0);
		int n;
		logic ah, rh;
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= !late;
		for (n = 0; n < 40; n++) begin
			@(negedge clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge clk);
			if (ah)
				arvalid <= 1'b0;
			if (rh && rready) begin
				rready <= 1'b0;
				break;
			end
			if (rh)
				rready <= 1'b1;
		end
		if (n == 40)
			hang("rvalid");
	endtask
	// Polls status or irq until it shows the expected value, then checks the delay window.
	task meas(input hjd_row_t r);
		int t0, n;
		logic ok;
		t0 = cyc;
		for (n = 0; n < 3000; n++) begin
			if (r.on_irq) begin
				@(negedge clk);
				d = {31'h0, irq};
			end else
				rd(`HJD_IDX_STATUS);
			if (d[7:0] === r.exp)
				break;
		end
		if (n == 3000)
			hang("status");
		ok = (cyc - t0 >= r.lo) && (cyc - t0 <= r.hi);
		chk("settle_window", ok, 1'b1);
	endtask
	initial begin
		rows = '{'{8'h02, 8'h00, 5'h16, 1'b0, 8'h70, 145, 200}, '{8'h02, 8'h00, 5'h00, 1'b0, 8'h00, 35, 75},
			'{8'h02, 8'h08, 5'h1c, 1'b0, 8'he0, 305, 360}, '{8'h02, 8'h0c, 5'h00, 1'b0, 8'h00, 15, 55},
			'{8'h02, 8'h10, 5'h1a, 1'b0, 8'hd0, 625, 690}, '{8'h06, 8'h10, 5'h00, 1'b0, 8'h00, 75, 135},
			'{8'h02, 8'h18, 5'h16, 1'b0, 8'h70, 1265, 1340}, '{8'h0a, 8'h1c, 5'h00, 1'b0, 8'h00, 75, 175},
			'{8'h02, 8'h20, 5'h16, 1'b0, 8'h70, 2545, 2620}, '{8'h0e, 8'h20, 5'h00, 1'b0, 8'h00, 35, 75},
			'{8'h02, 8'h28, 5'h16, 1'b0, 8'h70, 5105, 5180}, '{8'h02, 8'h28, 5'h00, 1'b0, 8'h00, 35, 75},
			'{8'h02, 8'h38, 5'h1a, 1'b0, 8'hd0, 0, 35}, '{8'h02, 8'h38, 5'h12, 1'b0, 8'h50, 0, 35},
			'{8'h02, 8'h78, 5'h14, 1'b0, 8'h60, 15, 55}, '{8'h02, 8'h7c, 5'h00, 1'b0, 8'h00, 15, 55},
			'{8'h02, 8'h30, 5'h16, 1'b0, 8'h70, 0, 35}, '{8'h02, 8'h30, 5'h17, 1'b1, 8'h01, 0, 35},
			'{8'h02, 8'h31, 5'h17, 1'b1, 8'h01, 0, 35}, '{8'h02, 8'h32, 5'h17, 1'b1, 8'h01, 5, 45},
			'{8'h02, 8'h33, 5'h17, 1'b1, 8'h01, 15, 55}};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wr(`HJD_IDX_IRQ_MASK, 8'h04);
		for (i = 0; i < 21; i++) begin
			wr(`HJD_IDX_CTRL, rows[i].ctrl);
			wr(`HJD_IDX_DEB_CFG, rows[i].cfg);
			@(posedge clk) jack <= rows[i].jack;
			meas(rows[i]);
			// A hook press leaves its sticky bit, cleared by the read that checks it; read again after the release has settled.
			if (rows[i].on_irq) begin
				rd(`HJD_IDX_IRQ_STAT);
				chk("hook_event", d[`HJD_IRQ_HOOK], 1'b1);
				@(posedge clk) jack <= 5'h16;
				repeat (60) @(posedge clk);
				rd(`HJD_IDX_IRQ_STAT);
			end
		end
		$display("debounce table done");
		@(posedge clk) rst_n <= 1'b0;
		jack <= 5'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(`HJD_IDX_DEB_CFG, 1'b1);
		chk("cfg_reset", d, 32'h0);
		rd(`HJD_IDX_STATUS);
		chk("status_reset", d, 32'h0);
		$display("reset test done");
		wr(`HJD_IDX_DEB_CFG, 8'h7f, 1'b1);
		rd(`HJD_IDX_DEB_CFG);
		chk("cfg_reserved", d, 32'h7f);
		wr(`HJD_IDX_STATUS, 8'hf0);
		chk("status_wr_resp", resp, `HJD_RESP_OKAY);
		rd(`HJD_IDX_STATUS);
		chk("status_read_only", d, 32'h0);
		rd(6'h01);
		chk("unmapped_resp", resp, `HJD_RESP_SLVERR);
		$display("reserved test done");
		wr(`HJD_IDX_DEB_CFG, 8'h38);
		wr(`HJD_IDX_IRQ_MASK, 8'h01);
		@(posedge clk) jack <= 5'h16;
		repeat (300) @(posedge clk);
		rd(`HJD_IDX_STATUS);
		chk("disabled_status", d, 32'h0);
		@(negedge clk);
		chk("disabled_irq", irq, 1'b0);
		wr(`HJD_IDX_CTRL, 8'h02);
		meas('{8'h02, 8'h38, 5'h16, 1'b0, 8'h70, 0, 60});
		@(negedge clk);
		chk("irq_raised", irq, 1'b1);
		wr(`HJD_IDX_IRQ_MASK, 8'h00);
		@(negedge clk);
		chk("irq_masked", irq, 1'b0);
		rd(`HJD_IDX_IRQ_STAT);
		chk("insert_event", d[`HJD_IRQ_INSERT], 1'b1);
		wr(`HJD_IDX_IRQ_MASK, 8'h01);
		@(negedge clk);
		chk("irq_cleared", irq, 1'b0);
		$display("enable and interrupt test done");
		end_sim();
	end
endmodule
`default_nettype wire

// *** hdl/hjd_consts.vh ***
// Register map, field layout, reset values and timing constants of the plug sense debounce block.
`ifndef HJD_CONSTS_VH
`define HJD_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define HJD_IDX_CTRL 6'h1a
`define HJD_IDX_DEB_CFG 6'h1b
`define HJD_IDX_STATUS 6'h1c
`define HJD_IDX_IRQ_STAT 6'h30
`define HJD_IDX_IRQ_MASK 6'h31

// Reset values of the writable and readable registers.
`define HJD_CTRL_RST 8'h00
`define HJD_DEB_CFG_RST 8'h00
`define HJD_STATUS_RST 8'h00
`define HJD_IRQ_RST 8'h00

// Writable bits of each register; reserved bits are never stored.
`define HJD_CTRL_WMASK 8'h0e
`define HJD_DEB_CFG_WMASK 8'h7f
`define HJD_IRQ_WMASK 8'h0f

// Control register fields.
`define HJD_CTRL_EN_BIT 1
`define HJD_CTRL_PER_LSB 2

// Debounce configuration register fields.
`define HJD_CFG_HP_BIT 6
`define HJD_CFG_INS_LSB 3
`define HJD_CFG_REM_BIT 2
`define HJD_CFG_HOOK_LSB 0

// Status register fields.
`define HJD_STAT_KIND_LSB 6
`define HJD_STAT_LAYOUT_LSB 4

// Plug kind and headset layout codes.
`define HJD_KIND_NONE 2'h0
`define HJD_KIND_NO_MIC 2'h1
`define HJD_KIND_MIC 2'h3
`define HJD_LAYOUT_NONE 2'h0
`define HJD_LAYOUT_RIGHT 2'h1
`define HJD_LAYOUT_LEFT 2'h2
`define HJD_LAYOUT_STEREO 2'h3

// Interrupt status bits.
`define HJD_IRQ_INSERT 0
`define HJD_IRQ_REMOVE 1
`define HJD_IRQ_HOOK 2
`define HJD_IRQ_LAYOUT 3

// Detection counts.
`define HJD_HP_DEB_COUNT 10'h003
`define HJD_REM_COUNT_SLOW 10'h005
`define HJD_REM_COUNT_FAST 10'h003
`define HJD_INS_BASE_MS 10'h010
`define HJD_INS_NO_DEB 3'h7
`define HJD_INS_RESERVED 3'h6

// Timing: base time unit of the sense period and the clock rate.
`define HJD_TICK_MS 1
`define HJD_CLK_KHZ 250000

// AXI response codes.
`define HJD_RESP_OKAY 2'h0
`define HJD_RESP_SLVERR 2'h2

`endif

// *** hdl/hjd_plug_sense_top.v ***
// Plug sense debounce, status reporting and AXI4-Lite register slave.
//
// Function
// RL1: Headphone debounce bit: none, or three detections.
// RL2: Insertion code sets 16 to 512 ms; 7 none.
// RL3: Removal needs five detections, or three when set.
// RL4: Hook codes 0,1 none; 2 two; 3 three.
// RL5: Plug kind at bits 7-6: none, no-mic, mic.
// RL6: Layout at bits 5-4: none, right, left, stereo.
// RL7: Reserved bits read zero; software writes zero.
// RL8: Debounce configuration at 0x1B resets to zero.
// RL9: Status at 0x1C resets to zero.
// RL10: Detection runs only while the enable is set.
// RL11: Sense period selectable 1, 2 or 4 ms.
// RL12: Count identical samples, restart on difference, then update.
// RL13: Status changes only after the filter accepts.
`timescale 1ns/1ps
`default_nettype none
`include "hjd_consts.vh"
module hjd_plug_sense_top #(
	parameter ADDR_W = 8,
	parameter TICK_CYCLES = `HJD_TICK_MS * `HJD_CLK_KHZ
) (
	input wire clk,
	input wire rst_n,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire plug_sense_raw,
	input wire hp_left_sense_raw,
	input wire hp_right_sense_raw,
	input wire mic_sense_raw,
	input wire hook_sense_raw,
	output reg irq
);

	// Software-visible registers.
	reg [7:0] ctrl_reg; // Enable and sense period.
	reg [7:0] deb_cfg_reg; // Debounce selectors.
	reg [7:0] status_reg; // Plug kind and headset layout.
	reg [7:0] irq_stat_reg; // Sticky event bits.
	reg [7:0] irq_mask_reg; // Event enables.

	// Field views of the control registers.
	wire plug_sense_enable = ctrl_reg[`HJD_CTRL_EN_BIT];
	wire [1:0] sense_period_sel = ctrl_reg[`HJD_CTRL_PER_LSB+1:`HJD_CTRL_PER_LSB];
	wire headphone_debounce_sel = deb_cfg_reg[`HJD_CFG_HP_BIT];
	wire [2:0] insertion_debounce_sel = deb_cfg_reg[`HJD_CFG_INS_LSB+2:`HJD_CFG_INS_LSB];
	wire removal_debounce_sel = deb_cfg_reg[`HJD_CFG_REM_BIT];
	wire [1:0] hook_button_debounce_sel = deb_cfg_reg[`HJD_CFG_HOOK_LSB+1:`HJD_CFG_HOOK_LSB];

	// Two-stage synchronisers for the comparator outputs, which are asynchronous.
	reg [4:0] sense_meta_reg;
	reg [4:0] sense_sync_reg;

	// The first stage feeds only the second stage.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_meta_reg <= 5'h00;
			sense_sync_reg <= 5'h00;
		end else begin
			sense_meta_reg <= {hook_sense_raw, mic_sense_raw, hp_left_sense_raw,
				hp_right_sense_raw, plug_sense_raw};
			sense_sync_reg <= sense_meta_reg;
		end
	end

	// Millisecond tick and sense period timers.
	reg [31:0] tick_cnt_reg;
	reg [1:0] period_cnt_reg;
	reg ms_tick_reg; // One pulse per millisecond.
	reg sample_tick_reg; // One pulse per sense period.
	reg [1:0] period_last;

	// Code 3 is reserved; it falls back to the shortest period rather than stalling.
	always @* begin
		case (sense_period_sel)
			2'h1: period_last = 2'h1;
			2'h2: period_last = 2'h3;
			default: period_last = 2'h0;
		endcase
	end

	// Both timers stop and rewind while detection is disabled.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 32'h00000000;
			period_cnt_reg <= 2'h0;
			ms_tick_reg <= 1'b0;
			sample_tick_reg <= 1'b0;
		end else if (!plug_sense_enable) begin
			// No sampling at all while disabled. [RL10]
			tick_cnt_reg <= 32'h00000000;
			period_cnt_reg <= 2'h0;
			ms_tick_reg <= 1'b0;
			sample_tick_reg <= 1'b0;
		end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
			tick_cnt_reg <= 32'h00000000;
			ms_tick_reg <= 1'b1;
			// A sample is taken every one, two or four milliseconds. [RL11]
			if (period_cnt_reg >= period_last) begin
				period_cnt_reg <= 2'h0;
				sample_tick_reg <= 1'b1;
			end else begin
				period_cnt_reg <= period_cnt_reg + 2'h1;
				sample_tick_reg <= 1'b0;
			end
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			ms_tick_reg <= 1'b0;
			sample_tick_reg <= 1'b0;
		end
	end

	// Filtered states.
	wire plug_state;
	wire [2:0] hp_state; // {mic, left, right}.
	wire hook_state;
	reg [9:0] hp_target;
	reg [9:0] plug_target;
	reg plug_strobe;
	reg [9:0] hook_target;

	// Debounce targets from the selectors.
	always @* begin
		// Headphone result: taken at once, or after three detections. [RL1]
		hp_target = headphone_debounce_sel ? `HJD_HP_DEB_COUNT : 10'h001;
		// Hook: codes 0 and 1 pass straight through, 2 and 3 need that many. [RL4]
		hook_target = (hook_button_debounce_sel[1]) ? {8'h00, hook_button_debounce_sel} : 10'h001;
		if (plug_state) begin
			// Removal counts detections at the sense period. [RL3]
			plug_strobe = sample_tick_reg;
			plug_target = removal_debounce_sel ? `HJD_REM_COUNT_FAST : `HJD_REM_COUNT_SLOW;
		end else if (insertion_debounce_sel == `HJD_INS_NO_DEB ||
			insertion_debounce_sel == `HJD_INS_RESERVED) begin
			// No insertion debounce; the reserved code behaves the same. [RL2]
			plug_strobe = sample_tick_reg;
			plug_target = 10'h001;
		end else begin
			// Insertion time counts milliseconds: 16 ms shifted by the code. [RL2]
			plug_strobe = ms_tick_reg;
			plug_target = `HJD_INS_BASE_MS << insertion_debounce_sel;
		end
	end

	// Plug presence filter with separate insertion and removal timing.
	hjd_sample_filter #(.DATA_W(1), .CNT_W(10)) u_plug_filter (
		.clk(clk),
		.rst_n(rst_n),
		.run(plug_sense_enable),
		.strobe(plug_strobe),
		.raw(sense_sync_reg[0]),
		.target(plug_target),
		.state_reg(plug_state)
	);

	// Headphone presence filter across right, left and microphone results.
	hjd_sample_filter #(.DATA_W(3), .CNT_W(10)) u_hp_filter (
		.clk(clk),
		.rst_n(rst_n),
		.run(plug_sense_enable),
		.strobe(sample_tick_reg),
		.raw(sense_sync_reg[3:1]),
		.target(hp_target),
		.state_reg(hp_state)
	);

	// Hook button filter.
	hjd_sample_filter #(.DATA_W(1), .CNT_W(10)) u_hook_filter (
		.clk(clk),
		.rst_n(rst_n),
		.run(plug_sense_enable),
		.strobe(sample_tick_reg),
		.raw(sense_sync_reg[4]),
		.target(hook_target),
		.state_reg(hook_state)
	);

	// Status fields built only from accepted states, never from raw samples.
	reg [1:0] plug_kind;
	reg [1:0] headset_layout_status;

	always @* begin
		if (!plug_state) begin
			plug_kind = `HJD_KIND_NONE; // [RL5]
			headset_layout_status = `HJD_LAYOUT_NONE; // [RL6]
		end else begin
			plug_kind = hp_state[2] ? `HJD_KIND_MIC : `HJD_KIND_NO_MIC; // [RL5]
			case (hp_state[1:0])
				2'h1: headset_layout_status = `HJD_LAYOUT_RIGHT; // [RL6]
				2'h2: headset_layout_status = `HJD_LAYOUT_LEFT; // [RL6]
				2'h3: headset_layout_status = `HJD_LAYOUT_STEREO; // [RL6]
				default: headset_layout_status = `HJD_LAYOUT_NONE;
			endcase
		end
	end

	// Events raised from changes of the registered status, and from a rising hook state.
	reg hook_prev_reg;
	wire [7:0] irq_set;
	wire [7:0] new_status = {plug_kind, headset_layout_status, 4'h0};
	assign irq_set = {4'h0,
		(new_status[5:4] != status_reg[5:4]) && plug_state,
		hook_state && !hook_prev_reg,
		(new_status[7:6] == `HJD_KIND_NONE) && (status_reg[7:6] != `HJD_KIND_NONE),
		(new_status[7:6] != `HJD_KIND_NONE) && (status_reg[7:6] == `HJD_KIND_NONE)};

	// Status register; reserved low nibble stays zero.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= `HJD_STATUS_RST; // [RL9]
			hook_prev_reg <= 1'b0;
		end else begin
			status_reg <= new_status; // [RL13] [RL7]
			hook_prev_reg <= hook_state;
		end
	end

	// Write channel state: address and data may arrive in either order.
	reg aw_have_reg;
	reg w_have_reg;
	reg [ADDR_W-1:0] waddr_reg;
	reg [7:0] wdata_reg;
	reg wstrb0_reg;
	wire [5:0] widx = waddr_reg[7:2];
	wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire wr_mapped = (widx == `HJD_IDX_CTRL) || (widx == `HJD_IDX_DEB_CFG) ||
		(widx == `HJD_IDX_STATUS) || (widx == `HJD_IDX_IRQ_STAT) || (widx == `HJD_IDX_IRQ_MASK);

	// Write handshakes; one write in flight, ready returns after the response is taken.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HJD_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= {ADDR_W{1'b0}};
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				waddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `HJD_RESP_OKAY : `HJD_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Writable registers; reserved bits are masked off so they always read zero.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `HJD_CTRL_RST;
			deb_cfg_reg <= `HJD_DEB_CFG_RST; // [RL8]
			irq_mask_reg <= `HJD_IRQ_RST;
		end else if (wr_fire && wstrb0_reg) begin
			if (widx == `HJD_IDX_CTRL) begin
				ctrl_reg <= wdata_reg & `HJD_CTRL_WMASK; // [RL7]
			end
			if (widx == `HJD_IDX_DEB_CFG) begin
				deb_cfg_reg <= wdata_reg & `HJD_DEB_CFG_WMASK; // [RL7]
			end
			if (widx == `HJD_IDX_IRQ_MASK) begin
				irq_mask_reg <= wdata_reg & `HJD_IRQ_WMASK;
			end
		end
	end

	// Read channel.
	wire [5:0] ridx = s_axi_araddr[7:2];
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_clear = rd_take && (ridx == `HJD_IDX_IRQ_STAT);
	reg [7:0] rd_mux;
	reg rd_hit;

	// Read decode; unmapped addresses answer with a slave error and zero data.
	always @* begin
		rd_hit = 1'b1;
		case (ridx)
			`HJD_IDX_CTRL: rd_mux = ctrl_reg;
			`HJD_IDX_DEB_CFG: rd_mux = deb_cfg_reg;
			`HJD_IDX_STATUS: rd_mux = status_reg;
			`HJD_IDX_IRQ_STAT: rd_mux = irq_stat_reg;
			`HJD_IDX_IRQ_MASK: rd_mux = irq_mask_reg;
			default: begin
				rd_mux = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read handshakes; data is captured when the address is taken.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `HJD_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_mux};
			s_axi_rresp <= rd_hit ? `HJD_RESP_OKAY : `HJD_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Sticky events cleared by a read; an event in the clearing cycle survives it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= `HJD_IRQ_RST;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (rd_clear ? 8'h00 : irq_stat_reg) | irq_set;
			irq <= |(((rd_clear ? 8'h00 : irq_stat_reg) | irq_set) & irq_mask_reg);
		end
	end

endmodule
`default_nettype wire

// *** hdl/hjd_sample_filter.v ***
// Consecutive-sample debounce filter used for every sensed input group.
`timescale 1ns/1ps
`default_nettype none
module hjd_sample_filter #(
	parameter DATA_W = 1,
	parameter CNT_W = 10
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire strobe,
	input wire [DATA_W-1:0] raw,
	input wire [CNT_W-1:0] target,
	output reg [DATA_W-1:0] state_reg
);

	// Candidate value being timed and how many samples in a row it has shown.
	reg [DATA_W-1:0] cand_reg;
	reg [CNT_W-1:0] cnt_reg;
	reg [CNT_W-1:0] cnt_next;

	// Count the samples that agree with the current candidate; a new value restarts at one.
	always @* begin
		if (raw == cand_reg && cnt_reg != {CNT_W{1'b1}}) begin
			cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// The accepted state only moves once the count reaches the target.
	// A target of zero or one means no filtering: the first differing sample is taken.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= {DATA_W{1'b0}};
			cand_reg <= {DATA_W{1'b0}};
			cnt_reg <= {CNT_W{1'b0}};
		end else if (!run) begin
			// Idle: forget any partial count, keep the last accepted state.
			cand_reg <= state_reg;
			cnt_reg <= {CNT_W{1'b0}};
		end else if (strobe) begin
			if (raw == state_reg) begin
				// Agreement with the accepted state cancels a pending change. [RL12]
				cand_reg <= raw;
				cnt_reg <= {CNT_W{1'b0}};
			end else if (cnt_next >= target) begin
				// Enough matching samples: accept the new value. [RL12] [RL13]
				state_reg <= raw;
				cand_reg <= raw;
				cnt_reg <= {CNT_W{1'b0}};
			end else begin
				// Keep counting, or restart when the sample changed. [RL12]
				cand_reg <= raw;
				cnt_reg <= cnt_next;
			end
		end
	end

endmodule
`default_nettype wire
